// ==== rtl/cirq_core.sv ====
// Purpose: Core interrupt request latch, pending bits and masking into one core interrupt
// Assumes: hwReq and nmiRaw synchronous to clk; nmiRaw active low at the pin
// Notes:   Pending bits, masks and level bits gate one core interrupt line
// Notes on behaviour
// - Taken non-maskable request redirects fetch to reset vector
// - Sample non-maskable input every rising clock edge
// - Inverted registered sample is the internal request
// - Non-maskable acts only while pipeline runs
// - No enable or mask blocks non-maskable request
// - Five hardware lines; top line never asserted
// - Hardware lines masked by bits 6..2, enable, levels
// - Software pending bits change only by writes
// - Software bits masked by bits 1..0, enable, levels
// - Counter equal to match sets timer pending
// - Timer masked by bit 7, enable, levels
// - Timer pending readable at reason bit 15
// - Hardware lines readable at reason bits 10..14
// - AND pending with mask, OR the eight
// - AND combined request with global enable
// - Exception level also gates core interrupt
// - Enable clear blocks the core interrupt only; reset, non-maskable and event interrupt pass
`timescale 1ns/10ps
`default_nettype none
module cirq_core
   import cirq_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdData,
   // Request sources
   input  wire logic        nmiRaw_n,
   input  wire logic [4:0]  hwReq,
   input  wire logic        pipeRun,
   input  wire logic        excTaken,
   // Core side
   output logic             coreIrq,
   output logic             nmiReq,
   output logic             fetchReset,
   output logic             eventIrq
);
   logic [15:0] stateReg;
   logic [1:0]  softReg;
   logic        timerReg;
   logic [15:0] countReg;
   logic [15:0] matchReg;
   logic [2:0]  evStatReg;
   logic [2:0]  evMaskReg;
   logic        nmiSampleReg;
   logic        nmiSeenReg;
   logic [7:0]  pending;
   logic [15:0] reasonView;
   logic        maskedAny;
   logic        timerHit;
   logic        fetchReset_next;
   logic [2:0]  evSet;

   // Decode a write strobe to one offset by address compare
   function automatic logic wrHit(input logic [3:0] a, input logic [3:0] ofs, input logic w);
      wrHit = w && (a == ofs);
   endfunction

   // Pending vector; top hardware line kept for reading but source never drives it
   assign pending = {timerReg, hwReq, softReg};
   assign reasonView = {pending, 8'h00};
   assign timerHit = (countReg == matchReg);

   // Per-source gating then global gating; exception and error level hold the core off
   assign maskedAny = |(pending & stateReg[POS_MASKLO +: 8]);
   assign coreIrq = maskedAny & stateReg[POS_ENABLE] & ~stateReg[POS_EXCLVL] & ~stateReg[POS_ERRLVL];

   // Internal non-maskable request is the inverted sample, bypassing all gating
   assign nmiReq = ~nmiSampleReg;

   // Redirect only while pipeline runs and on a fresh request
   assign fetchReset_next = nmiReq & pipeRun & ~nmiSeenReg;

   // Non-maskable sampler
   always_ff @(posedge clk) begin
      if (rst) begin
         nmiSampleReg <= 1'b1;
      end else begin
         nmiSampleReg <= nmiRaw_n;
      end
   end

   // Redirect pulse and one-shot tracking; request held while stalled waits
   always_ff @(posedge clk) begin
      if (rst) begin
         fetchReset <= 1'b0;
         nmiSeenReg <= 1'b0;
      end else begin
         fetchReset <= fetchReset_next;
         if (!nmiReq) begin
            nmiSeenReg <= 1'b0;
         end else if (fetchReset_next) begin
            nmiSeenReg <= 1'b1;
         end
      end
   end

   // State register; exception taken raises exception level
   always_ff @(posedge clk) begin
      if (rst) begin
         stateReg <= RST_STATE;
      end else if (wrHit(regAddr, OFS_STATE, regWr)) begin
         stateReg <= regWrData;
      end else if (excTaken) begin
         stateReg[POS_EXCLVL] <= 1'b1;
      end
   end

   // Software pending bits; only writes touch them
   always_ff @(posedge clk) begin
      if (rst) begin
         softReg <= RST_SOFT;
      end else if (wrHit(regAddr, OFS_REASON, regWr)) begin
         softReg <= regWrData[POS_PENDLO +: 2];
      end
   end

   // Timer pending: match sets it, a match-value write clears it; set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         timerReg <= 1'b0;
      end else if (timerHit) begin
         timerReg <= 1'b1;
      end else if (wrHit(regAddr, OFS_MATCH, regWr)) begin
         timerReg <= 1'b0;
      end
   end

   // Free-running counter, writable
   always_ff @(posedge clk) begin
      if (rst) begin
         countReg <= RST_COUNT;
      end else if (wrHit(regAddr, OFS_COUNT, regWr)) begin
         countReg <= regWrData;
      end else begin
         countReg <= countReg + 16'h0001;
      end
   end

   // Match value
   always_ff @(posedge clk) begin
      if (rst) begin
         matchReg <= RST_MATCH;
      end else if (wrHit(regAddr, OFS_MATCH, regWr)) begin
         matchReg <= regWrData;
      end
   end

   // Sticky event status; a new event beats a same-cycle clear
   assign evSet = {timerHit, fetchReset_next, coreIrq};
   always_ff @(posedge clk) begin
      if (rst) begin
         evStatReg <= RST_EV;
      end else if (wrHit(regAddr, OFS_EVSTAT, regWr)) begin
         evStatReg <= (evStatReg & ~regWrData[2:0]) | evSet;
      end else begin
         evStatReg <= evStatReg | evSet;
      end
   end

   // Event mask
   always_ff @(posedge clk) begin
      if (rst) begin
         evMaskReg <= RST_EV;
      end else if (wrHit(regAddr, OFS_EVMASK, regWr)) begin
         evMaskReg <= regWrData[2:0];
      end
   end

   assign eventIrq = |(evStatReg & evMaskReg);

   // Read data, one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdData <= 16'h0000;
      end else if (regRd) begin
         if (regAddr == OFS_STATE) begin
            regRdData <= stateReg;
         end else if (regAddr == OFS_REASON) begin
            regRdData <= reasonView;
         end else if (regAddr == OFS_COUNT) begin
            regRdData <= countReg;
         end else if (regAddr == OFS_MATCH) begin
            regRdData <= matchReg;
         end else if (regAddr == OFS_EVSTAT) begin
            regRdData <= {13'h0000, evStatReg};
         end else if (regAddr == OFS_EVMASK) begin
            regRdData <= {13'h0000, evMaskReg};
         end else begin
            regRdData <= RD_UNMAPPED;
         end
      end else begin
         regRdData <= 16'h0000;
      end
   end

   // Checks
   property p_nmiSample;
      @(posedge clk) disable iff (rst) nmiReq == !$past(nmiRaw_n);
   endproperty
   a_nmiSample: assert property (p_nmiSample) else $error("nmi sample wrong");

   property p_nmiStall;
      @(posedge clk) disable iff (rst) !pipeRun |=> !fetchReset;
   endproperty
   a_nmiStall: assert property (p_nmiStall) else $error("nmi acted while stalled");

   property p_nmiGo;
      @(posedge clk) disable iff (rst) (nmiReq && pipeRun && !nmiSeenReg) |=> fetchReset;
   endproperty
   a_nmiGo: assert property (p_nmiGo) else $error("nmi not redirected");

   property p_softHold;
      @(posedge clk) disable iff (rst) !(regWr && regAddr == OFS_REASON) |=> $stable(softReg);
   endproperty
   a_softHold: assert property (p_softHold) else $error("soft bit changed by hw");

   property p_timerSet;
      @(posedge clk) disable iff (rst) (countReg == matchReg) |=> reasonView[POS_TIMER];
   endproperty
   a_timerSet: assert property (p_timerSet) else $error("timer pending not set");

   property p_hwView;
      @(posedge clk) disable iff (rst) reasonView[POS_HWLO +: NUM_HW] == hwReq;
   endproperty
   a_hwView: assert property (p_hwView) else $error("hw lines not visible");

   property p_gate;
      @(posedge clk) disable iff (rst) coreIrq |-> (stateReg[POS_ENABLE] && !stateReg[POS_EXCLVL]
                                                   && |(pending & stateReg[15:8]));
   endproperty
   a_gate: assert property (p_gate) else $error("core irq ungated");

   property p_level;
      @(posedge clk) disable iff (rst) (stateReg == $past(stateReg) && pending == $past(pending)
                                        && $past(coreIrq)) |-> coreIrq;
   endproperty
   a_level: assert property (p_level) else $error("core irq dropped");

   // Redirect is a single pulse, rearms on release, and a stalled request is kept
   property p_nmiPulse;
      @(posedge clk) disable iff (rst) fetchReset |=> !fetchReset;
   endproperty
   a_nmiPulse: assert property (p_nmiPulse) else $error("redirect pulse too long");

   property p_nmiRearm;
      @(posedge clk) disable iff (rst) !nmiReq |=> !nmiSeenReg;
   endproperty
   a_nmiRearm: assert property (p_nmiRearm) else $error("nmi not rearmed");

   property p_nmiWait;
      @(posedge clk) disable iff (rst) (nmiReq && !nmiSeenReg && !pipeRun) |=> !nmiSeenReg;
   endproperty
   a_nmiWait: assert property (p_nmiWait) else $error("stalled nmi lost");

   // Open paths must reach the core; the gate check above alone would pass a stuck-low output
   property p_errGate;
      @(posedge clk) disable iff (rst) stateReg[POS_ERRLVL] |-> !coreIrq;
   endproperty
   a_errGate: assert property (p_errGate) else $error("error level did not block");

   property p_softOpen;
      @(posedge clk) disable iff (rst) (softReg[0] && stateReg[POS_MASKLO] && stateReg[POS_ENABLE]
                                        && !stateReg[POS_EXCLVL] && !stateReg[POS_ERRLVL]) |-> coreIrq;
   endproperty
   a_softOpen: assert property (p_softOpen) else $error("open soft request lost");

   property p_hwOpen;
      @(posedge clk) disable iff (rst) (|(hwReq & stateReg[POS_MASKLO + 2 +: NUM_HW]) && stateReg[POS_ENABLE]
                                        && !stateReg[POS_EXCLVL] && !stateReg[POS_ERRLVL]) |-> coreIrq;
   endproperty
   a_hwOpen: assert property (p_hwOpen) else $error("open hw request lost");

   property p_timerOpen;
      @(posedge clk) disable iff (rst) (timerReg && stateReg[POS_MASKLO + 7] && stateReg[POS_ENABLE]
                                        && !stateReg[POS_EXCLVL] && !stateReg[POS_ERRLVL]) |-> coreIrq;
   endproperty
   a_timerOpen: assert property (p_timerOpen) else $error("open timer request lost");

   property p_exlSet;
      @(posedge clk) disable iff (rst) (excTaken && !(regWr && regAddr == OFS_STATE)) |=> stateReg[POS_EXCLVL];
   endproperty
   a_exlSet: assert property (p_exlSet) else $error("exception level not raised");

   // Register writes land in the following cycle
   property p_stateWrite;
      @(posedge clk) disable iff (rst) (regWr && regAddr == OFS_STATE) |=> stateReg == $past(regWrData);
   endproperty
   a_stateWrite: assert property (p_stateWrite) else $error("state write lost");

   property p_softWrite;
      @(posedge clk) disable iff (rst) (regWr && regAddr == OFS_REASON) |=> softReg == $past(regWrData[POS_PENDLO +: 2]);
   endproperty
   a_softWrite: assert property (p_softWrite) else $error("soft write lost");

   property p_timerHold;
      @(posedge clk) disable iff (rst) (timerReg && !(regWr && regAddr == OFS_MATCH)) |=> timerReg;
   endproperty
   a_timerHold: assert property (p_timerHold) else $error("timer pending dropped");

   property p_timerClr;
      @(posedge clk) disable iff (rst) (regWr && regAddr == OFS_MATCH && countReg != matchReg) |=> !timerReg;
   endproperty
   a_timerClr: assert property (p_timerClr) else $error("timer pending not cleared");

   // Guarded by the sampled reset so the attempt at the releasing edge stays vacuous
   property p_countRun;
      @(posedge clk) disable iff (rst) (!rst && !(regWr && regAddr == OFS_COUNT))
                                       |=> countReg == $past(countReg) + 16'h0001;
   endproperty
   a_countRun: assert property (p_countRun) else $error("counter stalled");

   property p_countWrite;
      @(posedge clk) disable iff (rst) (regWr && regAddr == OFS_COUNT) |=> countReg == $past(regWrData);
   endproperty
   a_countWrite: assert property (p_countWrite) else $error("counter write lost");

   property p_matchWrite;
      @(posedge clk) disable iff (rst) (regWr && regAddr == OFS_MATCH) |=> matchReg == $past(regWrData);
   endproperty
   a_matchWrite: assert property (p_matchWrite) else $error("match write lost");

   // Event status keeps its bits until a one is written over them
   property p_evSticky;
      @(posedge clk) disable iff (rst) !(regWr && regAddr == OFS_EVSTAT)
                                       |=> (evStatReg & $past(evStatReg)) == $past(evStatReg);
   endproperty
   a_evSticky: assert property (p_evSticky) else $error("event bit lost");

   property p_evNmi;
      @(posedge clk) disable iff (rst) fetchReset_next |=> evStatReg[EV_NMI];
   endproperty
   a_evNmi: assert property (p_evNmi) else $error("redirect event not recorded");

   property p_evClear;
      @(posedge clk) disable iff (rst) (regWr && regAddr == OFS_EVSTAT && regWrData[EV_NMI] && !fetchReset_next)
                                       |=> !evStatReg[EV_NMI];
   endproperty
   a_evClear: assert property (p_evClear) else $error("event bit not cleared");

   property p_evMaskWrite;
      @(posedge clk) disable iff (rst) (regWr && regAddr == OFS_EVMASK) |=> evMaskReg == $past(regWrData[2:0]);
   endproperty
   a_evMaskWrite: assert property (p_evMaskWrite) else $error("event mask write lost");

   // Read data stands only in the cycle after the strobe
   property p_rdIdle;
      @(posedge clk) disable iff (rst) !regRd |=> regRdData == 16'h0000;
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");

   property p_rdState;
      @(posedge clk) disable iff (rst) (regRd && regAddr == OFS_STATE) |=> regRdData == $past(stateReg);
   endproperty
   a_rdState: assert property (p_rdState) else $error("state read wrong");

   property p_rdReason;
      @(posedge clk) disable iff (rst) (regRd && regAddr == OFS_REASON) |=> regRdData == $past(reasonView);
   endproperty
   a_rdReason: assert property (p_rdReason) else $error("reason read wrong");

   property p_rdUnmapped;
      @(posedge clk) disable iff (rst) (regRd && regAddr > OFS_EVMASK) |=> regRdData == RD_UNMAPPED;
   endproperty
   a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped read not zero");

   c_nmi: cover property (@(posedge clk) disable iff (rst) fetchReset);
   c_timer: cover property (@(posedge clk) disable iff (rst) timerReg && coreIrq);
   c_soft: cover property (@(posedge clk) disable iff (rst) softReg[0] && coreIrq);
   c_hwIrq: cover property (@(posedge clk) disable iff (rst) |(hwReq & stateReg[POS_MASKLO + 2 +: NUM_HW]) && coreIrq);
   c_event: cover property (@(posedge clk) disable iff (rst) eventIrq);
endmodule
`default_nettype wire

// ==== rtl/cirq_pkg.sv ====
// Purpose: Constants for the core interrupt request and masking logic
// Assumes: 20 MHz core clock, 16-bit register port
// Notes:   Offsets are word indices on the plain register port
package cirq_pkg;
   // Register offsets
   localparam logic [3:0] OFS_STATE   = 4'h0; // Processor state: mask, flags, enable
   localparam logic [3:0] OFS_REASON  = 4'h1; // Exception reason: pending bits
   localparam logic [3:0] OFS_COUNT   = 4'h2; // Free-running tick counter
   localparam logic [3:0] OFS_MATCH   = 4'h3; // Match value
   localparam logic [3:0] OFS_EVSTAT  = 4'h4; // Sticky event status, write one to clear
   localparam logic [3:0] OFS_EVMASK  = 4'h5; // Event interrupt mask
   // Field positions in state register
   localparam int POS_ENABLE  = 0;
   localparam int POS_EXCLVL  = 1;
   localparam int POS_ERRLVL  = 2;
   localparam int POS_MASKLO  = 8;
   // Field positions in reason register
   localparam int POS_PENDLO  = 8;
   localparam int POS_HWLO    = 10;
   localparam int POS_TIMER   = 15;
   // Event status bits
   localparam int EV_CORE     = 0;
   localparam int EV_NMI      = 1;
   localparam int EV_TIMER    = 2;
   // Reset values
   localparam logic [15:0] RST_STATE  = 16'h0004; // Error level set after reset
   localparam logic [1:0]  RST_SOFT   = 2'h0;
   localparam logic [15:0] RST_COUNT  = 16'h0000;
   localparam logic [15:0] RST_MATCH  = 16'hffff;
   localparam logic [2:0]  RST_EV     = 3'h0;
   localparam int          NUM_HW     = 5;
   // Unused register answer
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;
endpackage

// ==== verification/cirq_src_model.sv ====
// Purpose: Far-side model: interrupt control unit and pipeline sources
// Assumes: Bench commands change just after a rising edge
// Notes:   Idle non-maskable line rests high, like its pull-up
`timescale 1ns/10ps
`default_nettype none
module cirq_src_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Bench commands
   input  wire logic [3:0] reqIn,
   input  wire logic       nmiIn,
   input  wire logic       runIn,
   // Lines to the block
   output logic      [4:0] hwReq,
   output logic            nmiRaw_n,
   output logic            pipeRun
);
   // Launch on the edge so the block only sees synchronous levels
   always_ff @(posedge clk) begin
      if (rst) begin
         hwReq    <= 5'h00;
         nmiRaw_n <= 1'b1;
         pipeRun  <= 1'b0;
      end else begin
         hwReq    <= {1'b0, reqIn};
         nmiRaw_n <= ~nmiIn;
         pipeRun  <= runIn;
      end
   end
endmodule
`default_nettype wire

// ==== verification/cirq_core_tb.sv ====
// Purpose: Self-checking bench for the core interrupt request logic
// Assumes: Register reads answer one cycle after the strobe
// Notes:   Random masks and sources, then timer, level and NMI cases
`timescale 1ns/10ps
`default_nettype none
module cirq_core_tb;
   import cirq_pkg::*;
   logic        clk, rst, regWr, regRd, nmiIn, runIn, excTaken;
   logic [3:0]  regAddr, reqIn;
   logic [15:0] regWrData, regRdData, rdv, st;
   logic [4:0]  hwReq;
   logic        nmiRaw_n, pipeRun, coreIrq, nmiReq, fetchReset, eventIrq;
   logic [1:0]  sw;
   int          n_mismatch, checked, i, n;

   // Free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   cirq_core u_cirq_core (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .nmiRaw_n(nmiRaw_n), .hwReq(hwReq),
      .pipeRun(pipeRun), .excTaken(excTaken), .coreIrq(coreIrq), .nmiReq(nmiReq),
      .fetchReset(fetchReset), .eventIrq(eventIrq));
   cirq_src_model u_cirq_src_model (.clk(clk), .rst(rst), .reqIn(reqIn), .nmiIn(nmiIn),
      .runIn(runIn), .hwReq(hwReq), .nmiRaw_n(nmiRaw_n), .pipeRun(pipeRun));

   // Single comparison point, counts every check
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   // Bus cycles: one-cycle strobes launched just after an edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr     <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 rdv = regRdData; // Data stands only in this cycle
   endtask

   // Expected core request from state and pending views
   function automatic logic expIrq(input logic [15:0] s, input logic [7:0] p);
      return (|(p & s[15:8])) & s[0] & ~s[1] & ~s[2];
   endfunction

   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      {rst, regWr, regRd, nmiIn, runIn, excTaken} = 6'h20;
      {regAddr, reqIn, regWrData} = '0;
      n_mismatch = 0;
      checked = 0;
      void'($urandom(32'h396e));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_STATE);
      chk("state", RST_STATE, rdv);
      rd(OFS_MATCH);
      chk("match", RST_MATCH, rdv);
      rd(4'hf);
      chk("unmapped", RD_UNMAPPED, rdv);
      // Random masks, flags and sources; first pass is the all-open corner
      for (i = 0; i < 40; i++) begin
         st = (i == 0) ? 16'hff01 : 16'($urandom);
         sw = (i == 0) ? 2'h3 : 2'($urandom);
         wr(OFS_STATE, st);
         wr(OFS_REASON, {6'h00, sw, 8'h00});
         reqIn <= (i == 0) ? 4'h0 : 4'($urandom);
         repeat (3) @(posedge clk);
         rd(OFS_REASON);
         chk("reason", {2'h0, reqIn, sw, 8'h00}, rdv & 16'hff00);
         chk("coreirq", 16'(expIrq(st, {2'h0, reqIn, sw})), 16'(coreIrq));
      end
      // Timer match with only bit 7 open, then exception level closes it
      reqIn <= 4'h0;
      wr(OFS_REASON, 16'h0000);
      wr(OFS_STATE, 16'h8001);
      wr(OFS_MATCH, 16'h0030);
      wr(OFS_COUNT, 16'h0000);
      rd(OFS_COUNT);
      chk("count", 16'h0001, rdv);
      repeat (60) @(posedge clk);
      rd(OFS_REASON);
      chk("timer", 16'h8000, rdv & 16'hff00);
      chk("timerirq", 16'h0001, 16'(coreIrq));
      @(posedge clk);
      excTaken <= 1'b1;
      @(posedge clk);
      excTaken <= 1'b0;
      rd(OFS_STATE);
      chk("exclvl_state", 16'h8003, rdv);
      chk("exclvl", 16'h0000, 16'(coreIrq));
      wr(OFS_MATCH, 16'hffff);
      rd(OFS_REASON);
      chk("tclear", 16'h0000, rdv & 16'h8000);
      // Non-maskable request: held off while stalled, one redirect once running
      wr(OFS_STATE, 16'h0004);
      nmiIn <= 1'b1;
      n = 0;
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         #1 n += fetchReset;
      end
      chk("stall", 16'h0000, 16'(n));
      chk("nmireq", 16'h0001, 16'(nmiReq));
      @(posedge clk);
      runIn <= 1'b1;
      n = 0;
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         #1 n += fetchReset;
      end
      chk("redirect", 16'h0001, 16'(n));
      nmiIn <= 1'b0;
      // Event status raised, unmasked, then cleared
      rd(OFS_EVSTAT);
      chk("evnmi", 16'h0002, rdv & 16'h0002);
      wr(OFS_EVMASK, 16'h0002);
      #1 chk("evirq", 16'h0001, 16'(eventIrq));
      wr(OFS_EVSTAT, 16'h0002);
      #1 chk("evclr", 16'h0000, 16'(eventIrq));
      test_done();
   end
endmodule
`default_nettype wire
